// >>> rtl/ssc_defines.vh
// constants of the synchronous serial transmit and receive core
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
// control register fields
`define SSC_CR_RXLEN   2:0
`define SSC_CR_TXLEN   5:3
`define SSC_CR_SYNLEN  8:6
`define SSC_CR_PAREN   9
`define SSC_CR_PARODD  10
`define SSC_CR_X32     11
`define SSC_CR_MODE    13:12
`define SSC_CR_TRANSPARENT_SELECT   14
`define SSC_CTRL_RST   16'h01b6
// operating modes
`define SSC_MODE_0     2'h0
`define SSC_MODE_1     2'h1
`define SSC_MODE_2     2'h2
// parallel load selects
`define SSC_LD_CTRL    2'h0
`define SSC_LD_SYNCA   2'h1
`define SSC_LD_SYNCB   2'h2
// output select bit addresses
`define SSC_OB_TRANSMIT_ON   5'h10
`define SSC_OB_RTS     5'h11
`define SSC_OB_RXACK   5'h12
`define SSC_OB_CLRTX   5'h13
`define SSC_OB_CLRRX   5'h14
`define SSC_OB_RBRCRC  5'h15
`define SSC_OB_RBXCRC  5'h16
`define SSC_OB_RBHLD   5'h17
`define SSC_OB_ABTCLR  5'h18
`define SSC_OB_SOFTRST 5'h1f
// character length coding: length = code + base, 2 to 9 bits
`define SSC_LEN_BASE   4'h2
`define SSC_LEN_SPAN   4'ha
`define SSC_ALL1       9'h1ff
// divide-by-32 clock
`define SSC_X32_ARM    5'h1e
`define SSC_X32_LAST   5'h1f
`define SSC_X32_MID    5'h0f
// crc
`define SSC_CRC_POLY   16'h8005
`define SSC_CRC_INIT   16'h0000
// line levels and pin indices
`define SSC_MARK       1'b1
`define SSC_PIN_IDLE   1'b1
`define SSC_PIN_RIN    0
`define SSC_PIN_TCLK   1
`define SSC_PIN_RCLK   2
`define SSC_PIN_CTS    3
`define SSC_NPIN       4
`endif

// >>> rtl/ssc_pair_buf.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ssc_pair_buf #(
  parameter W = 13
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         reset_n,
  // filling side
  input  wire         in_valid,
  output reg          in_ready,
  input  wire [W-1:0] in_data,
  // draining side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg  [W-1:0] ent0;
  reg  [W-1:0] ent1;
  reg  [1:0]   fill;
  wire         push;
  wire         pop;
  wire [1:0]   next_fill;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (fill != 2'h0);
  assign out_data  = ent0;
  assign next_fill = fill + {1'b0, push} - {1'b0, pop};

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ent0     <= {W{1'b0}};
      ent1     <= {W{1'b0}};
      fill     <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      if (pop) begin
        ent0 <= (fill == 2'h2) ? ent1 : in_data;
      end else if (push) begin
        if (fill == 2'h0) begin
          ent0 <= in_data;
        end else begin
          ent1 <= in_data;
        end
      end
      fill     <= next_fill;
      in_ready <= (next_fill != 2'h2);
    end
  end
endmodule // ssc_pair_buf

// >>> rtl/ssc_core.v
// synchronous serial transmit and receive core
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_core (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // parallel register load
  input  wire        load_strobe,
  input  wire [1:0]  load_sel,
  input  wire [15:0] load_data,
  // output select bit commands
  input  wire        bit_wr,
  input  wire [4:0]  bit_addr,
  input  wire        bit_val,
  // input bit read
  input  wire [4:0]  rd_addr,
  output reg         rd_bit,
  output reg  [15:0] status_view,
  // transmit data stream
  input  wire        tx_valid,
  input  wire [8:0]  tx_data,
  output wire        tx_ready,
  // line pins
  input  wire        serial_in,
  input  wire        tx_bit_clock,
  input  wire        rx_bit_clock,
  input  wire        clear_send_n,
  output reg         serial_out,
  output reg         request_send_n
);
  function [3:0] len_of;
    input [2:0] code;
    len_of = {1'b0, code} + `SSC_LEN_BASE;
  endfunction

  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `SSC_CRC_POLY : 16'h0000);
  endfunction

  // pin synchronisers
  wire [`SSC_NPIN-1:0] pin_raw;
  reg  [`SSC_NPIN-1:0] pin_s0;
  reg  [`SSC_NPIN-1:0] pin_s1;
  reg  [`SSC_NPIN-1:0] pin_s2;
  reg  [`SSC_NPIN-1:0] pin_f;
  reg  [`SSC_NPIN-1:0] pin_p;

  assign pin_raw = {clear_send_n, rx_bit_clock, tx_bit_clock, serial_in};

  genvar g;
  generate
    for (g = 0; g < `SSC_NPIN; g = g + 1) begin : g_pin
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          pin_s0[g] <= `SSC_PIN_IDLE;
          pin_s1[g] <= `SSC_PIN_IDLE;
          pin_s2[g] <= `SSC_PIN_IDLE;
          pin_f[g]  <= `SSC_PIN_IDLE;
          pin_p[g]  <= `SSC_PIN_IDLE;
        end else begin
          pin_s0[g] <= pin_raw[g];
          pin_s1[g] <= pin_s0[g];
          pin_s2[g] <= pin_s1[g];
          if (pin_s1[g] == pin_s2[g]) begin
            pin_f[g] <= pin_s2[g];
          end
          pin_p[g] <= pin_f[g];
        end
      end
    end
  endgenerate

  wire rx_in    = pin_f[`SSC_PIN_RIN];
  wire tx_fall  = pin_p[`SSC_PIN_TCLK] & ~pin_f[`SSC_PIN_TCLK];
  wire rx_rise  = ~pin_p[`SSC_PIN_RCLK] & pin_f[`SSC_PIN_RCLK];
  wire cts_on   = ~pin_f[`SSC_PIN_CTS];
  wire cts_fall = pin_p[`SSC_PIN_CTS] & ~pin_f[`SSC_PIN_CTS];

  // registers and commands
  reg  [15:0] ctrl_reg;
  reg  [8:0]  sync_char_a;
  reg  [8:0]  sync_char_b;
  reg         transmit_on;
  reg         rts_forced;
  reg         rts_level;
  reg         rb_rcrc;
  reg         rb_xcrc;
  reg         rb_hold;

  wire cmd          = bit_wr & bit_val;
  wire soft_rst     = cmd & (bit_addr == `SSC_OB_SOFTRST);
  wire clear_transmitter = soft_rst | (cmd & (bit_addr == `SSC_OB_CLRTX));
  wire clear_receiver    = soft_rst | (cmd & (bit_addr == `SSC_OB_CLRRX));
  wire rx_ack       = bit_wr & (bit_addr == `SSC_OB_RXACK);
  wire abort_clr    = bit_wr & (bit_addr == `SSC_OB_ABTCLR);
  wire [1:0] mode   = ctrl_reg[`SSC_CR_MODE];
  wire par_en       = ctrl_reg[`SSC_CR_PAREN] & (mode != `SSC_MODE_1);
  wire par_odd      = ctrl_reg[`SSC_CR_PARODD];
  wire clock_x32_select = ctrl_reg[`SSC_CR_X32];
  wire transparent_select = ctrl_reg[`SSC_CR_TRANSPARENT_SELECT];
  wire [3:0] sync_length = len_of(ctrl_reg[`SSC_CR_SYNLEN]);
  wire [3:0] rx_len_sel  = len_of(ctrl_reg[`SSC_CR_RXLEN]);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg    <= `SSC_CTRL_RST;
      sync_char_a <= 9'h000;
      sync_char_b <= 9'h000;
      transmit_on <= 1'b0;
      rts_forced  <= 1'b0;
      rts_level   <= 1'b0;
      rb_rcrc     <= 1'b0;
      rb_xcrc     <= 1'b0;
      rb_hold     <= 1'b0;
    end else begin
      if (load_strobe) begin
        case (load_sel)
          `SSC_LD_CTRL:  ctrl_reg <= load_data;
          `SSC_LD_SYNCA: sync_char_a <= load_data[8:0];
          `SSC_LD_SYNCB: sync_char_b <= load_data[8:0];
          default:       ctrl_reg <= ctrl_reg;
        endcase
      end
      if (bit_wr) begin
        case (bit_addr)
          `SSC_OB_TRANSMIT_ON:  transmit_on <= bit_val;
          `SSC_OB_RBRCRC: rb_rcrc <= bit_val;
          `SSC_OB_RBXCRC: rb_xcrc <= bit_val;
          `SSC_OB_RBHLD:  rb_hold <= bit_val;
          default:        rb_hold <= rb_hold;
        endcase
      end
      if (clear_transmitter) begin
        rts_forced <= 1'b0;
      end else if (bit_wr & (bit_addr == `SSC_OB_RTS)) begin
        rts_forced <= 1'b1;
        rts_level  <= bit_val;
      end
    end
  end

  // transmit buffer, each entry carries its own length
  wire        buf_valid;
  wire [12:0] buf_data;
  wire        tx_pop;
  wire        tx_buffer_empty = ~buf_valid;

  ssc_pair_buf #(.W(13)) u_tx_buffer (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({len_of(ctrl_reg[`SSC_CR_TXLEN]), tx_data}),
    .out_valid (buf_valid),
    .out_ready (tx_pop),
    .out_data  (buf_data)
  );

  // transmitter
  reg        tx_busy;
  reg [8:0]  tx_shift_reg;
  reg [3:0]  tx_bit_counter;
  reg        tx_parity_acc;
  reg        tx_par_pend;
  reg        tx_abort;
  reg        tx_crc_en;
  reg [15:0] tx_crc;
  reg [4:0]  tx_x32_cnt;
  reg        tx_x32_run;
  reg        auto_request_send;

  wire x32_tx = clock_x32_select & cts_on;
  wire tx_shift_strobe = tx_fall & (~x32_tx |
                         (tx_x32_run & (tx_x32_cnt == `SSC_X32_LAST)));
  wire tx_last = ((tx_bit_counter == 4'h1) & ~tx_par_pend) | (tx_bit_counter == 4'h0);
  wire tx_step = tx_shift_strobe & tx_busy & ~clear_transmitter;
  assign tx_pop = tx_step & tx_last & buf_valid;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_x32_cnt <= 5'h00;
      tx_x32_run <= 1'b0;
    end else if (clock_x32_select & cts_fall & pin_f[`SSC_PIN_TCLK]) begin
      tx_x32_cnt <= `SSC_X32_ARM;
      tx_x32_run <= 1'b1;
    end else if (~cts_on) begin
      tx_x32_run <= 1'b0;
    end else if (tx_fall & tx_x32_run) begin
      tx_x32_cnt <= tx_x32_cnt + 5'h01;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy           <= 1'b0;
      tx_shift_reg      <= 9'h000;
      tx_bit_counter    <= 4'h0;
      tx_parity_acc     <= 1'b0;
      tx_par_pend       <= 1'b0;
      tx_abort          <= 1'b0;
      tx_crc_en         <= 1'b0;
      tx_crc            <= `SSC_CRC_INIT;
      serial_out        <= `SSC_MARK;
      auto_request_send <= 1'b0;
      request_send_n    <= 1'b1;
    end else begin
      auto_request_send <= transmit_on | tx_busy;
      if (tx_fall) begin
        request_send_n <= ~(rts_forced ? rts_level : auto_request_send);
      end
      if (abort_clr) begin
        tx_abort <= 1'b0;
      end
      if (clear_transmitter) begin
        tx_busy     <= 1'b0;
        tx_par_pend <= 1'b0;
        tx_abort    <= 1'b0;
        tx_parity_acc <= 1'b0;
        tx_crc      <= `SSC_CRC_INIT;
        serial_out  <= `SSC_MARK;
      end else if (tx_shift_strobe & ~tx_busy) begin
        if (transmit_on & cts_on & ~tx_abort) begin
          tx_busy        <= 1'b1;
          tx_shift_reg   <= sync_char_a;
          tx_bit_counter <= sync_length;
          tx_par_pend    <= 1'b0;
          tx_crc_en      <= 1'b0;
        end else begin
          // last bit of the final character has had its full bit time
          serial_out     <= `SSC_MARK;
        end
      end else if (tx_step) begin
        if (tx_bit_counter != 4'h0) begin
          serial_out     <= tx_shift_reg[0];
          tx_parity_acc  <= tx_parity_acc ^ tx_shift_reg[0];
          tx_shift_reg   <= tx_shift_reg >> 1;
          tx_bit_counter <= tx_bit_counter - 4'h1;
          if (tx_crc_en) begin
            tx_crc <= crc_step(tx_crc, tx_shift_reg[0]);
          end
        end else begin
          serial_out  <= tx_parity_acc ^ par_odd;
          tx_par_pend <= 1'b0;
        end
        if (tx_last) begin
          tx_parity_acc <= 1'b0;
          if (buf_valid) begin
            tx_shift_reg   <= buf_data[8:0];
            tx_bit_counter <= buf_data[12:9];
            tx_par_pend    <= par_en;
            tx_crc_en      <= 1'b1;
          end else if (~transmit_on | ~cts_on) begin
            tx_busy <= 1'b0;
          end else if ((mode == `SSC_MODE_0) & ~transparent_select) begin
            tx_busy  <= 1'b0;
            tx_abort <= 1'b1;
          end else begin
            tx_shift_reg   <= sync_char_b;
            tx_bit_counter <= sync_length;
            tx_par_pend    <= 1'b0;
            tx_crc_en      <= 1'b0;
          end
        end
      end
    end
  end

  // receiver
  reg        rx_busy_init;
  reg [8:0]  rx_shift_reg;
  reg [3:0]  rx_bit_counter;
  reg        rx_parity_acc;
  reg        rx_par_wait;
  reg        rx_hunt;
  reg [8:0]  rx_buffer;
  reg        rx_buffer_loaded;
  reg        rx_overrun;
  reg        rx_parity_error;
  reg [15:0] rx_mask;
  reg [15:0] rx_crc;
  reg [4:0]  rx_x32_cnt;

  wire rx_init = clear_receiver;
  wire rx_shift_strobe = rx_rise & (~clock_x32_select | (rx_x32_cnt == `SSC_X32_MID));
  wire [8:0] rx_next = (rx_shift_reg >> 1) |
                       ({8'h00, rx_in} << (rx_bit_counter - 4'h1));
  wire [8:0] len_mask = `SSC_ALL1 >> (4'h9 - rx_bit_counter);
  wire [8:0] init_pat = `SSC_ALL1 >> (`SSC_LEN_SPAN - rx_len_sel);
  wire [8:0] hunt_pat = `SSC_ALL1 >> (4'h9 - rx_len_sel);
  wire       hunt_mode = (mode == `SSC_MODE_2);
  wire       rx_done = rx_shift_strobe & ~rx_par_wait & ~rx_hunt & ~rx_shift_reg[0];
  wire       rx_xfer = (rx_done & ~par_en) | (rx_shift_strobe & rx_par_wait);
  wire       rx_match = ((rx_next & len_mask) == (sync_char_a & len_mask));

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy_init     <= 1'b1;
      rx_shift_reg     <= 9'h000;
      rx_bit_counter   <= 4'h0;
      rx_parity_acc    <= 1'b0;
      rx_par_wait      <= 1'b0;
      rx_hunt          <= 1'b0;
      rx_buffer        <= 9'h000;
      rx_buffer_loaded <= 1'b0;
      rx_overrun       <= 1'b0;
      rx_parity_error  <= 1'b0;
      rx_mask          <= 16'hffff;
      rx_crc           <= `SSC_CRC_INIT;
      rx_x32_cnt       <= 5'h00;
    end else if (rx_init | rx_busy_init) begin
      rx_busy_init     <= 1'b0;
      rx_mask          <= 16'hffff;
      rx_shift_reg     <= hunt_mode ? hunt_pat : init_pat;
      rx_bit_counter   <= rx_len_sel;
      rx_parity_acc    <= 1'b0;
      rx_par_wait      <= 1'b0;
      rx_hunt          <= hunt_mode;
      rx_buffer_loaded <= 1'b0;
      rx_overrun       <= 1'b0;
      rx_parity_error  <= 1'b0;
      rx_crc           <= `SSC_CRC_INIT;
      rx_x32_cnt       <= 5'h00;
    end else begin
      if (rx_rise & clock_x32_select) begin
        rx_x32_cnt <= rx_x32_cnt + 5'h01;
      end
      if (rx_ack) begin
        rx_buffer_loaded <= 1'b0;
        rx_overrun       <= 1'b0;
      end
      if (rx_shift_strobe) begin
        rx_mask <= {rx_in, rx_mask[15:1]};
      end
      if (rx_shift_strobe & rx_hunt) begin
        rx_shift_reg <= rx_next;
        if (rx_match) begin
          rx_hunt      <= 1'b0;
          rx_shift_reg <= init_pat;
          rx_bit_counter <= rx_len_sel;
        end
      end else if (rx_shift_strobe & ~rx_par_wait) begin
        rx_shift_reg <= rx_next;
        rx_crc       <= crc_step(rx_crc, rx_in);
        if (mode != `SSC_MODE_1) begin
          rx_parity_acc <= rx_parity_acc ^ rx_in;
        end
        if (rx_done & par_en) begin
          rx_par_wait <= 1'b1;
        end
      end
      if (rx_xfer) begin
        rx_buffer        <= rx_par_wait ? rx_shift_reg : rx_next;
        rx_buffer_loaded <= 1'b1;
        rx_overrun       <= rx_buffer_loaded;
        rx_parity_error  <= rx_par_wait & ((rx_parity_acc ^ par_odd) != rx_in);
        rx_par_wait      <= 1'b0;
        rx_parity_acc    <= 1'b0;
        rx_bit_counter   <= rx_len_sel;
        rx_shift_reg     <= init_pat;
      end
    end
  end

  // status readback
  wire [15:0] flags_view = {rx_in, 3'b000, rx_overrun, rx_parity_error,
                            rx_overrun | rx_parity_error, rx_buffer};
  wire [15:0] low_view = rb_rcrc ? rx_crc :
                         rb_xcrc ? tx_crc :
                         rb_hold ? rx_mask : flags_view;
  wire [15:0] high_view = {3'b000, cts_on, 1'b0, auto_request_send, 2'b00,
                           tx_abort, tx_buffer_empty, rx_buffer_loaded, 5'h00};
  wire [31:0] all_view  = {high_view, low_view};

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_view <= 16'h0000;
      rd_bit      <= 1'b0;
    end else begin
      status_view <= low_view;
      rd_bit      <= all_view[rd_addr];
    end
  end
endmodule // ssc_core

// >>> sim/ssc_core_chk.sv
// port-level assertions for the serial core
`timescale 1ns/1ps
module ssc_core_chk (
  // clock and reset
  input wire        core_clk,
  input wire        reset_n,
  // commands and reads
  input wire        bit_wr,
  input wire [4:0]  bit_addr,
  input wire        bit_val,
  input wire [4:0]  rd_addr,
  input wire        rd_bit,
  input wire [15:0] status_view,
  // stream and line
  input wire        tx_valid,
  input wire        tx_ready,
  input wire        tx_bit_clock,
  input wire        request_send_n
);
  reg [4:0] since_fall;
  reg       tclk_d;
  reg       rb;
  reg       rb_sel;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // cycles since the raw transmit clock fell, saturating when it stops
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_fall <= 5'h1f;
      tclk_d <= 1'b1;
      rb <= 1'b0;
      rb_sel <= 1'b0;
    end else begin
      tclk_d <= tx_bit_clock;
      if (tclk_d && !tx_bit_clock) since_fall <= 5'h00;
      else if (since_fall != 5'h1f) since_fall <= since_fall + 5'h01;
      // readback view lingers one cycle after its select drops
      if (bit_wr && bit_addr >= 5'h15 && bit_addr <= 5'h17) rb_sel <= bit_val;
      rb <= rb_sel | (bit_wr && bit_val && bit_addr >= 5'h15 && bit_addr <= 5'h17);
    end
  end
  property p_rts_on_fall; $changed(request_send_n) |-> since_fall inside {[3:7]}; endproperty
  property p_rts_forced; bit_wr && bit_addr == 5'h11 && bit_val |-> ##[1:20] !request_send_n;
  endproperty
  property p_ready_drain; $rose(tx_ready) |-> since_fall < 5'h08; endproperty
  property p_ready_fall; $fell(tx_ready) |-> $past(tx_valid) || $past(tx_valid, 2); endproperty
  property p_rd_view;
    !$past(rd_addr[4]) |-> rd_bit == status_view[$past(rd_addr[3:0])];
  endproperty
  property p_err_sum; !rb |-> status_view[9] == (status_view[11] | status_view[10]); endproperty
  property p_zero_field; !rb |-> status_view[14:12] == 3'h0; endproperty
  property p_ack; bit_wr && bit_addr == 5'h12 && !rb |-> ##2 !status_view[11]; endproperty
  property p_clr_rx;
    bit_wr && bit_addr == 5'h14 && bit_val && !rb |-> ##2 status_view[11:9] == 3'h0;
  endproperty
  a_rts_on_fall: assert property (p_rts_on_fall) else $error("rts moved off a clock fall");
  a_rts_forced: assert property (p_rts_forced) else $error("forced rts not applied");
  a_ready_drain: assert property (p_ready_drain) else $error("buffer drained w/o strobe");
  a_ready_fall: assert property (p_ready_fall) else $error("ready fell without a word");
  a_rd_view: assert property (p_rd_view) else $error("read bit differs from view");
  a_err_sum: assert property (p_err_sum) else $error("error summary bit wrong");
  a_zero_field: assert property (p_zero_field) else $error("unused view bits set");
  a_ack: assert property (p_ack) else $error("overrun not cleared by ack");
  a_clr_rx: assert property (p_clr_rx) else $error("receiver flags survive clear");
  c_full: cover property ($fell(tx_ready));
  c_rts: cover property ($fell(request_send_n));
  c_perr: cover property ($rose(status_view[10]));
endmodule // ssc_core_chk

bind ssc_core ssc_core_chk u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .bit_wr(bit_wr), .bit_addr(bit_addr),
  .bit_val(bit_val), .rd_addr(rd_addr), .rd_bit(rd_bit), .status_view(status_view),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_bit_clock(tx_bit_clock),
  .request_send_n(request_send_n)
);

// >>> sim/ssc_line_model.sv
// line-side model: bit clocks, receive data source, transmit capture
`timescale 1ns/1ps
module ssc_line_model (
  // control from bench
  input  wire        tx_run,
  input  wire        rx_go,
  input  wire [31:0] rx_pat,
  input  wire [5:0]  rx_len,
  // line pins
  input  wire        serial_out,
  output reg         tx_bit_clock,
  output reg         rx_bit_clock,
  output reg         serial_in,
  // observation
  output reg         rx_busy,
  output reg  [63:0] tx_hist
);
  integer i;
  initial begin
    tx_bit_clock = 1'b1;
    rx_bit_clock = 1'b1;
    serial_in = 1'b1;
    rx_busy = 1'b0;
    tx_hist = {64{1'b1}};
  end
  // 160 ns bit clock, edges offset from the core clock
  always #80 if (tx_run) tx_bit_clock = ~tx_bit_clock;
  // newest bit enters at the top, sampled just before the next update
  always @(negedge tx_bit_clock) tx_hist <= {serial_out, tx_hist[63:1]};
  // receive clock runs only while a frame is sent
  always @(posedge rx_go) begin
    rx_busy = 1'b1;
    for (i = 0; i < rx_len; i = i + 1) begin
      rx_bit_clock = 1'b0;
      serial_in = rx_pat[i];
      #80;
      rx_bit_clock = 1'b1;
      #80;
    end
    serial_in = ~serial_in;
    rx_busy = 1'b0;
  end
endmodule // ssc_line_model

// >>> sim/testbench.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
module testbench;
  reg         core_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         load_strobe = 1'b0;
  reg  [1:0]  load_sel = 2'h0;
  reg  [15:0] load_data = 16'h0000;
  reg         bit_wr = 1'b0;
  reg  [4:0]  bit_addr = 5'h00;
  reg         bit_val = 1'b0;
  reg  [4:0]  rd_addr = 5'h00;
  reg         tx_valid = 1'b0;
  reg  [8:0]  tx_data = 9'h000;
  reg         clear_send_n = 1'b1;
  reg         tx_run = 1'b0;
  reg         rx_go = 1'b0;
  wire        rd_bit;
  wire [15:0] status_view;
  wire        tx_ready;
  wire        serial_in;
  wire        tx_bit_clock;
  wire        rx_bit_clock;
  wire        serial_out;
  wire        request_send_n;
  wire        rx_busy;
  wire [63:0] tx_hist;
  integer     n_errors = 0;
  integer     tests_run = 0;
  always #10 core_clk = ~core_clk;
  ssc_core u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .load_strobe(load_strobe), .load_sel(load_sel),
    .load_data(load_data), .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_val(bit_val),
    .rd_addr(rd_addr), .rd_bit(rd_bit), .status_view(status_view), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .serial_in(serial_in),
    .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .clear_send_n(clear_send_n),
    .serial_out(serial_out), .request_send_n(request_send_n)
  );
  // frame: 4'h5 lead-in, sync 8'h16, 8'ha5 + good parity, 8'h3c + bad parity
  ssc_line_model u_line (
    .tx_run(tx_run), .rx_go(rx_go), .rx_pat(32'h278a5165), .rx_len(6'd30),
    .serial_out(serial_out), .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock),
    .serial_in(serial_in), .rx_busy(rx_busy), .tx_hist(tx_hist)
  );
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // b=1: bit command at a with d[0]; b=0: register load with select a[1:0]
  task wr(input b, input [4:0] a, input [15:0] d);
    begin
      @(posedge core_clk);
      bit_wr <= b;
      load_strobe <= !b;
      bit_addr <= a;
      load_sel <= a[1:0];
      bit_val <= d[0];
      load_data <= d;
      @(posedge core_clk);
      bit_wr <= 1'b0;
      load_strobe <= 1'b0;
    end
  endtask
  task rdb(input [4:0] a);
    begin
      @(posedge core_clk);
      rd_addr <= a;
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
  task push(input [8:0] d);
    integer n;
    begin
      n = 0;
      @(posedge core_clk);
      tx_valid <= 1'b1;
      tx_data <= d;
      #1;
      while (tx_ready !== 1'b1 && n < 100) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      chk(n < 100, 1);
      @(posedge core_clk);
      tx_valid <= 1'b0;
    end
  endtask
  task t_stream;
    integer i;
    reg hit;
    begin
      hit = 1'b0;
      wr(0, 5'h00, 16'h47ae);
      wr(1, 5'h13, 16'h0001);
      wr(0, 5'h01, 16'h0016);
      wr(0, 5'h02, 16'h0069);
      push(9'h055);
      push(9'h00f);
      repeat (2) @(posedge core_clk);
      #1 chk(tx_ready, 0);
      rdb(5'd22);
      chk(rd_bit, 0);
      clear_send_n <= 1'b0;
      tx_run <= 1'b1;
      wr(1, 5'h10, 16'h0001);
      repeat (500) @(posedge core_clk);
      #1 chk(request_send_n, 0);
      // sync a, two 7-bit words with odd parity, then sync b
      for (i = 0; i <= 32; i = i + 1)
        if (tx_hist[i +: 32] === 32'h698fd516) hit = 1'b1;
      chk(hit, 1);
      wr(1, 5'h10, 16'h0000);
      repeat (300) @(posedge core_clk);
      #1 chk({serial_out, request_send_n}, 2'b11);
      $display("test stream done");
    end
  endtask
  task t_abort;
    begin
      wr(0, 5'h00, 16'h07ae);
      wr(1, 5'h13, 16'h0001);
      push(9'h033);
      wr(1, 5'h10, 16'h0001);
      repeat (400) @(posedge core_clk);
      rdb(5'd23);
      chk({rd_bit, serial_out, tx_ready}, 3'b111);
      wr(1, 5'h10, 16'h0000);
      wr(1, 5'h18, 16'h0000);
      rdb(5'd23);
      chk(rd_bit, 0);
      $display("test abort done");
    end
  endtask
  task t_rts;
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        wr(1, 5'h11, {15'h0000, k != 1});
        repeat (24) @(posedge core_clk);
        #1 chk(request_send_n, k == 1);
      end
      wr(1, 5'h13, 16'h0001);
      repeat (24) @(posedge core_clk);
      #1 chk(request_send_n, 1);
      $display("test rts done");
    end
  endtask
  task t_rx;
    integer n;
    begin
      n = 0;
      tx_run <= 1'b0;
      wr(0, 5'h00, 16'h23b6);
      wr(0, 5'h01, 16'h0016);
      wr(1, 5'h14, 16'h0001);
      rx_go <= 1'b1;
      @(posedge core_clk);
      rx_go <= 1'b0;
      #1;
      while (rx_busy === 1'b1 && n < 1000) begin
        @(posedge core_clk);
        n = n + 1;
      end
      chk(n < 1000, 1);
      repeat (20) @(posedge core_clk);
      #1 chk(status_view, 16'h0e3c);
      wr(1, 5'h12, 16'h0000);
      rdb(5'd21);
      chk(rd_bit, 0);
      chk(status_view, 16'h063c);
      wr(1, 5'h14, 16'h0001);
      rdb(5'd21);
      chk({rd_bit, status_view[11:9]}, 4'h0);
      wr(1, 5'h17, 16'h0001);
      repeat (2) @(posedge core_clk);
      #1 chk(status_view, 16'hffff);
      wr(1, 5'h17, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1 chk(status_view[14:9], 6'h00);
      $display("test receive done");
    end
  endtask
  task results;
    begin
      $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 chk({serial_out, request_send_n, tx_ready}, 3'b111);
    chk(status_view, 16'h8000);
    rdb(5'd30);
    chk(rd_bit, 0);
    rdb(5'd22);
    chk(rd_bit, 1);
    t_stream;
    t_abort;
    t_rts;
    t_rx;
    results;
  end
  initial begin
    #500000;
    n_errors = n_errors + 1;
    results;
  end
endmodule // testbench
